// ==== src/mmc_pkg.sv ====
package mmc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and start-up timing
  localparam int CLK_KHZ           = 25000;
  localparam int MEM_CHECK_MS      = 5;
  localparam int MEM_CHECK_CYCLES  = MEM_CHECK_MS * CLK_KHZ;

  ////////////////////////////////////////////////////////////////////////////
  // Pin classification from the analog front end
  typedef enum logic [1:0] {
    PIN_LOW  = 2'h0,
    PIN_OPEN = 2'h1,
    PIN_HIGH = 2'h2,
    PIN_RES  = 2'h3
  } mmc_kind_t;

  typedef struct packed {
    mmc_kind_t   kind;
    logic [4:0]  idx;
  } mmc_pin_t;

  localparam int          PIN_W        = 7;
  localparam logic [4:0]  IDX_STD_MAX  = 5'h18;  // 100k, last standard value
  localparam logic [4:0]  IDX_TRIM_EN  = 5'h19;  // 110k on fine pin
  localparam logic [4:0]  IDX_UNRECOG  = 5'h1f;  // No matching resistor

  typedef enum logic [1:0] {
    TRIM_STD  = 2'h0,
    TRIM_POLA = 2'h1,
    TRIM_DOSA = 2'h2
  } mmc_trim_t;

  ////////////////////////////////////////////////////////////////////////////
  // Voltage arithmetic, millivolts
  localparam logic [12:0] COARSE_WEIGHT = 13'h0019;  // 25 steps per coarse index
  localparam logic [12:0] STEP_MV       = 13'h000a;  // 10 mV
  localparam logic [12:0] VOUT_MIN_MV   = 13'h0258;  // 600 mV
  localparam logic [12:0] OUTPUT_VOLTAGE_CEILING_MV   = 13'h1388;  // 5000 mV
  localparam logic [12:0] DEFAULT_MV    = 13'h0258;  // Fallback target
  localparam logic [16:0] CEIL_NUM      = 17'h0000b;
  localparam logic [16:0] CEIL_DEN      = 17'h0000a;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_TARGET  = 8'h08;
  localparam logic [7:0] REG_CEILING = 8'h0c;
  localparam logic [7:0] REG_ADDR    = 8'h10;
  localparam logic [7:0] REG_PINS    = 8'h14;

  // Control fields
  localparam int CTRL_RESTORE   = 0;
  localparam int CTRL_TRIM_LO   = 1;
  localparam int CTRL_TRIM_HI   = 2;
  localparam int CTRL_TRIM_SET  = 3;
  // Status fields
  localparam int STAT_READY     = 0;
  localparam int STAT_ERROR     = 1;
  localparam int STAT_TRIM_LO   = 2;
  localparam int STAT_TRIM_HI   = 3;
  localparam int STAT_NVM       = 4;
  localparam int STAT_BUSY      = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [7:0]   paddr;
    logic [31:0]  pwdata;
  } mmc_apb_req_t;

  typedef struct packed {
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
  } mmc_apb_rsp_t;

  typedef struct packed {
    logic [12:0]  voutMv;
    logic [12:0]  ceilingMv;
    logic [6:0]   busAddr;
    mmc_trim_t    trimMode;
  } mmc_cfg_t;

endpackage

// ==== src/mmc_pin_sync.sv ====
`timescale 1ns/1ps
// Two-stage synchroniser for the strap classification word
module mmc_pin_sync #(
  parameter int W = 28
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          resetn,
  // Asynchronous in, synchronised out
  input  wire logic [W-1:0]  asyncIn,
  output logic      [W-1:0]  syncOut
);

  logic [W-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      stage1  <= '0;
      syncOut <= '0;
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule

// ==== src/mmc_vout_map.sv ====
`timescale 1ns/1ps
// Standard strap / resistor mapping of the voltage pin pair
module mmc_vout_map (
  // Latched pin classes
  input  mmc_pkg::mmc_pin_t  finePin,
  input  mmc_pkg::mmc_pin_t  coarsePin,
  // Decoded result
  output logic [12:0]        stdMv,
  output logic               stdValid,
  output logic               trimStrap
);
  import mmc_pkg::*;

  // Strap row/column lookup, nine voltages
  function automatic logic [12:0] strapMv(input mmc_kind_t row, input mmc_kind_t col);
    logic [3:0] sel;
    sel = {row, col};
    case (sel)
      {PIN_LOW,  PIN_LOW }: strapMv = 13'h0258;
      {PIN_LOW,  PIN_OPEN}: strapMv = 13'h0320;
      {PIN_LOW,  PIN_HIGH}: strapMv = 13'h03e8;
      {PIN_OPEN, PIN_LOW }: strapMv = 13'h04b0;
      {PIN_OPEN, PIN_OPEN}: strapMv = 13'h05dc;
      {PIN_OPEN, PIN_HIGH}: strapMv = 13'h0708;
      {PIN_HIGH, PIN_LOW }: strapMv = 13'h09c4;
      {PIN_HIGH, PIN_OPEN}: strapMv = 13'h0ce4;
      {PIN_HIGH, PIN_HIGH}: strapMv = 13'h1388;
      default:              strapMv = 13'h0000;
    endcase
  endfunction

  logic [12:0] resMv;
  logic        bothStrap;
  logic        bothRes;

  // Resistor mode: 10 mV x (25 x coarse + fine)
  always_comb begin
    resMv     = 13'((COARSE_WEIGHT * 13'(coarsePin.idx) + 13'(finePin.idx)) * STEP_MV);
    bothStrap = (finePin.kind != PIN_RES) && (coarsePin.kind != PIN_RES);
    bothRes   = (finePin.kind == PIN_RES) && (coarsePin.kind == PIN_RES);
    trimStrap = bothRes && (finePin.idx == IDX_TRIM_EN);
    stdMv     = 13'h0000;
    stdValid  = 1'b0;
    if (bothStrap) begin
      stdMv    = strapMv(coarsePin.kind, finePin.kind);
      stdValid = 1'b1;
    end else if (bothRes && coarsePin.idx <= IDX_STD_MAX && finePin.idx <= IDX_STD_MAX) begin
      stdMv    = resMv;
      stdValid = (resMv >= VOUT_MIN_MV) && (resMv <= OUTPUT_VOLTAGE_CEILING_MV);
    end
  end

endmodule

// ==== src/mmc_config_loader.sv ====
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// Multi-mode strap configuration loader with APB register access
module mmc_config_loader
  import mmc_pkg::*;
#(
  parameter int          MEM_CHECK_CYC = mmc_pkg::MEM_CHECK_CYCLES,
  parameter logic [6:0]  ADDR_BASE     = 7'h20,  // Arbitrary strap address base
  parameter logic [6:0]  ADDR_RES_BASE = 7'h40   // Arbitrary resistor address base
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              resetn,
  // APB slave
  input  mmc_pkg::mmc_apb_req_t  apbReq,
  output mmc_pkg::mmc_apb_rsp_t  apbRsp,
  // Strap pin classes from the analog front end
  input  mmc_pkg::mmc_pin_t      voutFineSelectPin,
  input  mmc_pkg::mmc_pin_t      voutCoarseSelectPin,
  input  mmc_pkg::mmc_pin_t      busAddrSelectPinA,
  input  mmc_pkg::mmc_pin_t      busAddrSelectPinB,
  // Internal memory image
  input  wire logic              nvmValid,
  input  wire logic [12:0]       nvmVoutMv,
  input  mmc_pkg::mmc_trim_t     nvmTrimMode,
  // Configuration out
  output mmc_pkg::mmc_cfg_t      cfg,
  output logic                   deviceReady,
  output logic                   configError
);

  ////////////////////////////////////////////////////////////////////////////
  // Types and declarations
  typedef enum logic [2:0] {
    ST_MEMCHK  = 3'b001,
    ST_PINLOAD = 3'b010,
    ST_READY   = 3'b100
  } mmc_state_t;

  localparam int CNT_W = $clog2(MEM_CHECK_CYC + 1);

  mmc_state_t         state;
  logic [CNT_W-1:0]   memCount;
  logic [4*PIN_W-1:0] pinSync;
  mmc_pin_t           fineS;
  mmc_pin_t           coarseS;
  mmc_pin_t           addrAS;
  mmc_pin_t           addrBS;
  mmc_pin_t           fineL;
  mmc_pin_t           coarseL;
  mmc_pin_t           addrAL;
  mmc_pin_t           addrBL;
  logic               nvmLoaded;
  logic [12:0]        stdMv;
  logic               stdValid;
  logic               trimStrap;
  logic [12:0]        next_pinMv;
  logic               next_pinOk;
  mmc_trim_t          next_pinTrim;
  logic [6:0]         next_addr;
  logic               next_addrOk;
  logic               setupPhase;
  logic               accessDone;
  logic               wrCtrl;
  logic               wrTarget;
  logic               restoreReq;
  logic [31:0]        readData;
  logic               accessErr;
  mmc_trim_t          swTrim;
  logic [12:0]        swTrimMv;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Trim-mode table keyed by the coarse resistor index; zero means no entry
  function automatic logic [12:0] trimMv(input logic [4:0] idx);
    case (idx)
      5'h1d:   trimMv = 13'h02bc;  // 0.700 V
      5'h19:   trimMv = 13'h02f0;  // 0.752 V
      5'h18:   trimMv = 13'h02f6;  // 0.758 V
      5'h17:   trimMv = 13'h02fd;  // 0.765 V
      5'h16:   trimMv = 13'h0304;  // 0.772 V
      5'h15:   trimMv = 13'h0316;  // 0.790 V
      5'h12:   trimMv = 13'h0320;  // 0.800 V
      5'h11:   trimMv = 13'h0335;  // 0.821 V
      5'h10:   trimMv = 13'h0342;  // 0.834 V
      5'h0f:   trimMv = 13'h0350;  // 0.848 V
      5'h0d:   trimMv = 13'h0370;  // 0.880 V
      5'h0c:   trimMv = 13'h0383;  // 0.899 V
      5'h0b:   trimMv = 13'h0397;  // 0.919 V
      5'h09:   trimMv = 13'h03c5;  // 0.965 V
      5'h08:   trimMv = 13'h03df;  // 0.991 V
      5'h07:   trimMv = 13'h03e8;  // 1.000 V
      5'h05:   trimMv = 13'h044c;  // 1.100 V
      5'h03:   trimMv = 13'h0486;  // 1.158 V
      5'h02:   trimMv = 13'h04b0;  // 1.200 V
      default: trimMv = 13'h0000;
    endcase
  endfunction

  // Ceiling is ten percent above the pin-selected voltage
  function automatic logic [12:0] ceilingOf(input logic [12:0] mv);
    logic [16:0] scaled;
    scaled    = (17'(mv) * CEIL_NUM) / CEIL_DEN;
    ceilingOf = scaled[12:0];
  endfunction

  // Pin class byte for readback
  function automatic logic [7:0] pinByte(input mmc_pin_t p);
    pinByte = {1'b0, p};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs: two flops before any decode
  mmc_pin_sync #(
    .W (4 * PIN_W)
  ) u_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .asyncIn  ({voutFineSelectPin, voutCoarseSelectPin, busAddrSelectPinA, busAddrSelectPinB}),
    .syncOut  (pinSync)
  );

  assign {fineS, coarseS, addrAS, addrBS} = pinSync;

  // Standard mapping on the latched pins
  mmc_vout_map u_map (
    .finePin   (fineL),
    .coarsePin (coarseL),
    .stdMv     (stdMv),
    .stdValid  (stdValid),
    .trimStrap (trimStrap)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Start-up sequencer: memory check, pin load, ready
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state    <= ST_MEMCHK;
      memCount <= '0;
    end else begin
      case (state)
        ST_MEMCHK: begin
          if (memCount == CNT_W'(MEM_CHECK_CYC - 1)) begin
            memCount <= '0;
            state    <= ST_PINLOAD;
          end else begin
            memCount <= memCount + 1'b1;
          end
        end
        ST_PINLOAD: begin
          state <= ST_READY;
        end
        ST_READY: begin
          if (restoreReq) begin
            state <= ST_MEMCHK;
          end
        end
        default: begin
          state    <= ST_MEMCHK;
          memCount <= '0;
        end
      endcase
    end
  end

  // Ready only after memory and pins are both loaded
  // Restore drops it on the same edge that restarts the check
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      deviceReady <= 1'b0;
    end else begin
      deviceReady <= (state == ST_PINLOAD) || (state == ST_READY && !restoreReq);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin latch: sampled once per memory check, held otherwise
  // Later resistor changes are ignored until the next check
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      fineL   <= '0;
      coarseL <= '0;
      addrAL  <= '0;
      addrBL  <= '0;
    end else if (state == ST_MEMCHK && memCount == CNT_W'(MEM_CHECK_CYC - 1)) begin
      fineL   <= fineS;
      coarseL <= coarseS;
      addrAL  <= addrAS;
      addrBL  <= addrBS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin decode of voltage and address
  // A miss in any table keeps the safe default and flags an error
  always_comb begin
    next_pinMv   = DEFAULT_MV;
    next_pinOk   = 1'b0;
    next_pinTrim = TRIM_STD;
    if (trimStrap) begin
      next_pinTrim = TRIM_POLA;
      if (trimMv(coarseL.idx) != 13'h0000) begin
        next_pinMv = trimMv(coarseL.idx);
        next_pinOk = 1'b1;
      end
    end else if (stdValid) begin
      next_pinMv = stdMv;
      next_pinOk = 1'b1;
    end
  end

  always_comb begin
    next_addr   = ADDR_BASE;
    next_addrOk = 1'b0;
    if (addrAL.kind == PIN_RES) begin
      if (addrAL.idx != IDX_UNRECOG) begin
        next_addr   = 7'(ADDR_RES_BASE + 7'(addrAL.idx));
        next_addrOk = 1'b1;
      end
    end else if (addrBL.kind != PIN_RES) begin
      next_addr   = 7'(ADDR_BASE + 7'(addrBL.kind) * 7'h3 + 7'(addrAL.kind));
      next_addrOk = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: answer set up in the setup cycle, committed in the access cycle
  assign setupPhase = apbReq.psel && !apbReq.penable;
  assign accessDone = apbReq.psel && apbReq.penable && apbRsp.pready;
  assign wrCtrl     = accessDone && apbReq.pwrite && !apbRsp.pslverr && apbReq.paddr == REG_CTRL;
  assign wrTarget   = accessDone && apbReq.pwrite && !apbRsp.pslverr && apbReq.paddr == REG_TARGET;
  assign restoreReq = wrCtrl && apbReq.pwdata[CTRL_RESTORE];
  assign swTrim     = mmc_trim_t'(apbReq.pwdata[CTRL_TRIM_HI:CTRL_TRIM_LO]);
  // A strapped coarse pin carries no usable index, so it has no table entry
  assign swTrimMv   = (coarseL.kind == PIN_RES) ? trimMv(coarseL.idx)
                                                : 13'h0000;

  // Read mux; every pin-derived value stays visible
  always_comb begin
    readData = 32'h0000_0000;
    case (apbReq.paddr)
      REG_CTRL:    readData[CTRL_TRIM_HI:CTRL_TRIM_LO] = cfg.trimMode;
      REG_STATUS: begin
        readData[STAT_READY]                = deviceReady;
        readData[STAT_ERROR]                = configError;
        readData[STAT_TRIM_HI:STAT_TRIM_LO] = cfg.trimMode;
        readData[STAT_NVM]                  = nvmLoaded;
        readData[STAT_BUSY]                 = (state != ST_READY);
      end
      REG_TARGET:  readData[12:0] = cfg.voutMv;
      REG_CEILING: readData[12:0] = cfg.ceilingMv;
      REG_ADDR:    readData[6:0]  = cfg.busAddr;
      REG_PINS:    readData = {pinByte(fineL), pinByte(coarseL), pinByte(addrAL), pinByte(addrBL)};
      default:     readData = 32'h0000_0000;
    endcase
  end

  // Error: unmapped, read-only written, bad target, bad trim select, or not yet ready
  always_comb begin
    accessErr = 1'b0;
    if (!deviceReady && apbReq.paddr != REG_STATUS) begin
      accessErr = 1'b1;
    end else if (apbReq.pwrite) begin
      case (apbReq.paddr)
        // Code 3 is unused; refusing it keeps the mode field defined
        REG_CTRL:   accessErr = apbReq.pwdata[CTRL_TRIM_SET]
                                && ((swTrim != TRIM_STD && swTrimMv == 13'h0000)
                                    || !(swTrim inside {TRIM_STD, TRIM_POLA, TRIM_DOSA}));
        REG_TARGET: accessErr = (apbReq.pwdata[12:0] < VOUT_MIN_MV) || (apbReq.pwdata[12:0] > OUTPUT_VOLTAGE_CEILING_MV)
                                || (apbReq.pwdata[31:13] != 19'h00000);
        default:    accessErr = 1'b1;
      endcase
    end else begin
      case (apbReq.paddr)
        REG_CTRL, REG_STATUS, REG_TARGET, REG_CEILING, REG_ADDR, REG_PINS: accessErr = 1'b0;
        default: accessErr = 1'b1;
      endcase
    end
  end

  // Response registers, one wait-free access phase
  // No wait states: the answer is formed from the setup cycle
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      apbRsp <= '0;
    end else if (setupPhase) begin
      apbRsp.pready  <= 1'b1;
      apbRsp.pslverr <= accessErr;
      apbRsp.prdata  <= apbReq.pwrite ? 32'h0000_0000 : readData;
    end else begin
      apbRsp <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration store: memory image, then pins, then bus overrides
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cfg.voutMv   <= DEFAULT_MV;
      cfg.trimMode <= TRIM_STD;
      nvmLoaded    <= 1'b0;
    end else if (state == ST_MEMCHK && memCount == '0) begin
      nvmLoaded <= nvmValid;
      if (nvmValid) begin
        cfg.voutMv   <= nvmVoutMv;
        cfg.trimMode <= nvmTrimMode;
      end
    end else if (state == ST_PINLOAD) begin
      cfg.voutMv   <= next_pinMv;
      cfg.trimMode <= next_pinTrim;
    end else if (wrTarget) begin
      cfg.voutMv <= apbReq.pwdata[12:0];
    end else if (wrCtrl && apbReq.pwdata[CTRL_TRIM_SET]) begin
      cfg.trimMode <= swTrim;
      if (swTrim != TRIM_STD) begin
        cfg.voutMv <= swTrimMv;
      end
    end
  end

  // Pin-only values: ceiling and bus address, never bus-written
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cfg.ceilingMv <= ceilingOf(DEFAULT_MV);
      cfg.busAddr   <= ADDR_BASE;
    end else if (state == ST_PINLOAD) begin
      cfg.ceilingMv <= ceilingOf(next_pinMv);
      cfg.busAddr   <= next_addr;
    end
  end

  // Sticky decode error until the next sample
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      configError <= 1'b0;
    end else if (state == ST_PINLOAD) begin
      configError <= !next_pinOk || !next_addrOk;
    end
  end

endmodule

// ==== dv/mmc_config_checker.sv ====
`timescale 1ns/1ps
module mmc_config_checker
  import mmc_pkg::*;
#(
  parameter int MEM_CHECK_CYC = 8
) (
  // Clock and reset
  input wire logic             core_clk,
  input wire logic             resetn,
  // Register bus
  input mmc_pkg::mmc_apb_req_t apbReq,
  input mmc_pkg::mmc_apb_rsp_t apbRsp,
  // Configuration out
  input mmc_pkg::mmc_cfg_t     cfg,
  input wire logic             deviceReady,
  input wire logic             configError
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////
  // Bus phase decode
  wire logic setup  = apbReq.psel && !apbReq.penable;
  wire logic wrDone = apbRsp.pready && apbReq.pwrite && !apbRsp.pslverr;

  ////////////////////////////////////////////////////////////////////////////
  // Bus timing and refusals
  AST_ANSWER: assert property (setup |=> apbRsp.pready)
    else $error("no answer one cycle after setup");
  AST_PULSE: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("ready held longer than one cycle");
  AST_REFUSE: assert property (setup && !deviceReady && apbReq.paddr != REG_STATUS ##1 !deviceReady
    |-> apbRsp.pslverr) else $error("access accepted before ready");
  AST_TARGET: assert property (wrDone && apbReq.paddr == REG_TARGET
    |=> cfg.voutMv == $past(apbReq.pwdata[12:0])) else $error("target write not applied");

  ////////////////////////////////////////////////////////////////////////////
  // Start-up, restore and latching
  AST_START: assert property ($rose(resetn) |-> !deviceReady[*8] ##[1:30] deviceReady)
    else $error("ready outside start-up window");
  AST_RESTORE: assert property (wrDone && apbReq.paddr == REG_CTRL && apbReq.pwdata[CTRL_RESTORE]
    |-> ##[1:2] !deviceReady) else $error("restore did not restart sampling");
  AST_PIN_ONLY: assert property (deviceReady && $past(deviceReady)
    |-> $stable(cfg.ceilingMv) && $stable(cfg.busAddr)) else $error("pin-only value moved");
  AST_LATCHED: assert property (deviceReady && $past(deviceReady) && !$past(wrDone)
    |-> $stable(cfg)) else $error("config moved without a sample or write");
  AST_RANGE: assert property (deviceReady
    |-> cfg.voutMv >= VOUT_MIN_MV && cfg.voutMv <= OUTPUT_VOLTAGE_CEILING_MV) else $error("target out of range");

  // Not-ready cycles before each rise of ready; the whole memory check must pass
  int busyCnt;
  always_ff @(posedge core_clk) begin
    if (!resetn || deviceReady) begin
      busyCnt <= 0;
    end else begin
      busyCnt <= busyCnt + 1;
    end
  end
  AST_CHECK_LEN: assert property ($rose(deviceReady) |-> busyCnt >= MEM_CHECK_CYC)
    else $error("ready before the memory check ended");

  // Main scenarios reached
  cover property ($rose(deviceReady) && configError);
  cover property (wrDone && apbReq.paddr == REG_TARGET);
  cover property (deviceReady && cfg.trimMode == TRIM_POLA);
endmodule

// ==== dv/mmc_strap_model.sv ====
`timescale 1ns/1ps
module mmc_strap_model (
  // Per pin: -1 low, -2 open, -3 high, else resistor in 100 ohm units
  input  int                 fineConn,
  input  int                 coarseConn,
  input  int                 addrAConn,
  input  int                 addrBConn,
  // Classified pins
  output mmc_pkg::mmc_pin_t  voutFineSelectPin,
  output mmc_pkg::mmc_pin_t  voutCoarseSelectPin,
  output mmc_pkg::mmc_pin_t  busAddrSelectPinA,
  output mmc_pkg::mmc_pin_t  busAddrSelectPinB
);
  import mmc_pkg::*;
  // Every fourth standard value, then the trim enable value
  localparam int STD_R [26] = '{100, 110, 121, 133, 147, 162, 178, 196, 215, 237, 261, 287, 316,
                                348, 383, 422, 464, 511, 562, 619, 681, 750, 825, 909, 1000, 1100};

  // Front end classification; strapped pins carry no index
  function automatic mmc_pin_t classify(input int conn);
    mmc_pin_t p;
    p = '{kind: PIN_RES, idx: IDX_UNRECOG};
    if (conn == -1) p.kind = PIN_LOW;
    else if (conn == -2) p.kind = PIN_OPEN;
    else if (conn == -3) p.kind = PIN_HIGH;
    else begin
      for (int i = 0; i < 26; i++) begin
        if (STD_R[i] == conn) p.idx = 5'(i);
      end
    end
    return p;
  endfunction

  // Resistors are static, so classes follow the connections
  assign voutFineSelectPin   = classify(fineConn);
  assign voutCoarseSelectPin = classify(coarseConn);
  assign busAddrSelectPinA   = classify(addrAConn);
  assign busAddrSelectPinB   = classify(addrBConn);
endmodule

// ==== dv/mmc_config_loader_bench.sv ====
`timescale 1ns/1ps
module mmc_config_loader_bench;
  import mmc_pkg::*;
  localparam int MEM_CHECK_CYC = 8;
  logic          core_clk = 1'b0;
  logic          resetn = 1'b0;
  mmc_apb_req_t  apbReq = '0;
  mmc_apb_rsp_t  apbRsp;
  int            fineConn = -1;
  int            coarseConn = -1;
  int            addrAConn = -1;
  int            addrBConn = -1;
  mmc_pin_t      finePin, coarsePin, pinA, pinB;
  mmc_cfg_t      cfg;
  logic          deviceReady, configError;
  logic [31:0]   rd;
  logic          err;
  int            mismatches = 0;
  int            totalChecks = 0;

  // Clock and watchdog
  always #20 core_clk = ~core_clk;
  initial begin
    #(40 * 5000);
    mismatches++;
    end_sim();
  end

  mmc_strap_model mmc_strap_model_i (.fineConn(fineConn), .coarseConn(coarseConn), .addrAConn(addrAConn),
    .addrBConn(addrBConn), .voutFineSelectPin(finePin), .voutCoarseSelectPin(coarsePin),
    .busAddrSelectPinA(pinA), .busAddrSelectPinB(pinB));
  // Memory image held fixed; pins must win over it
  mmc_config_loader #(.MEM_CHECK_CYC(MEM_CHECK_CYC)) mmc_config_loader_i (.core_clk(core_clk),
    .resetn(resetn), .apbReq(apbReq), .apbRsp(apbRsp), .voutFineSelectPin(finePin),
    .voutCoarseSelectPin(coarsePin), .busAddrSelectPinA(pinA), .busAddrSelectPinB(pinB),
    .nvmValid(1'b1), .nvmVoutMv(13'h03e8), .nvmTrimMode(TRIM_STD), .cfg(cfg),
    .deviceReady(deviceReady), .configError(configError));

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // One transfer; idle edge after it so the next setup never collides
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    @(posedge core_clk);
    while (apbRsp.pready !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    chk("bus answer", 1, apbRsp.pready);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
    @(posedge core_clk);
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge core_clk);
    while (deviceReady !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    chk("ready", 1, deviceReady);
  endtask

  task automatic restore(input int f, input int c, input int a, input int b);
    fineConn <= f;
    coarseConn <= c;
    addrAConn <= a;
    addrBConn <= b;
    apb(1'b1, REG_CTRL, 32'h1);
    repeat (3) @(posedge core_clk);
    chk("busy in restore", 0, deviceReady);
    chk("memory image first", 1000, cfg.voutMv);
    wait_ready();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_early();
    apb(1'b0, REG_TARGET, 32'h0);
    chk("early target err", 1, err);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("early status err", 0, err);
    wait_ready();
    chk("pins over memory", 600, cfg.voutMv);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status", 32'h11, rd & 32'h33);
    $display("t_early done");
  endtask

  task automatic t_strap();
    int mv[9] = '{600, 800, 1000, 1200, 1500, 1800, 2500, 3300, 5000};
    for (int r = 0; r < 3; r++) begin
      for (int f = 0; f < 3; f++) begin
        restore(-1 - f, -1 - r, -1 - f, -1 - r);
        chk("strap vout", mv[r * 3 + f], cfg.voutMv);
        chk("strap ceiling", mv[r * 3 + f] * 11 / 10, cfg.ceilingMv);
        chk("strap addr", 32'h20 + 3 * r + f, cfg.busAddr);
      end
    end
    $display("t_strap done");
  endtask

  task automatic t_res();
    int wv[4] = '{2500, 5001, 599, 600};
    int last;
    logic bad;
    restore(215, 162, 237, -3);
    chk("res vout", 1330, cfg.voutMv);
    chk("res ceiling", 1463, cfg.ceilingMv);
    chk("res addr", 32'h49, cfg.busAddr);
    fineConn <= 100;
    coarseConn <= 100;
    repeat (20) @(posedge core_clk);
    chk("latched vout", 1330, cfg.voutMv);
    apb(1'b0, REG_CEILING, 32'h0);
    chk("ceiling readback", 1463, rd);
    apb(1'b0, REG_ADDR, 32'h0);
    chk("addr readback", 32'h49, rd);
    apb(1'b0, REG_PINS, 32'h0);
    chk("pins readback", 32'h6865695f, rd);
    apb(1'b0, REG_TARGET, 32'h0);
    chk("target readback", 1330, rd);
    last = 1330;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, REG_TARGET, wv[i]);
      bad = wv[i] < 600 || wv[i] > 5000;
      if (!bad) last = wv[i];
      chk("target err", bad, err);
      chk("target vout", last, cfg.voutMv);
    end
    apb(1'b1, REG_CEILING, 32'h0);
    chk("ceiling write err", 1, err);
    apb(1'b1, REG_ADDR, 32'h0);
    chk("addr write err", 1, err);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", 1, err);
    chk("addr kept", 32'h49, cfg.busAddr);
    chk("ceiling kept", 1463, cfg.ceilingMv);
    $display("t_res done");
  endtask

  task automatic t_trim();
    apb(1'b1, REG_CTRL, 32'ha);
    chk("bus table vout", 1100, cfg.voutMv);
    chk("bus table mode", TRIM_POLA, cfg.trimMode);
    apb(1'b1, REG_CTRL, 32'hc);
    chk("bus second mode", TRIM_DOSA, cfg.trimMode);
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl readback", 32'h4, rd);
    apb(1'b1, REG_CTRL, 32'he);
    chk("bad trim err", 1, err);
    chk("bad trim kept", TRIM_DOSA, cfg.trimMode);
    restore(1100, 162, -1, -1);
    chk("strap table vout", 1100, cfg.voutMv);
    chk("strap table mode", TRIM_POLA, cfg.trimMode);
    chk("strap table ceiling", 1210, cfg.ceilingMv);
    $display("t_trim done");
  endtask

  task automatic t_err();
    restore(200, 162, -1, -1);
    chk("unknown fine vout", 600, cfg.voutMv);
    chk("unknown fine flag", 1, configError);
    restore(100, 121, -1, -1);
    chk("low sum vout", 600, cfg.voutMv);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status error bit", 1, rd[STAT_ERROR]);
    $display("t_err done");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    t_early();
    t_strap();
    t_res();
    t_trim();
    t_err();
    end_sim();
  end
endmodule

bind mmc_config_loader mmc_config_checker #(.MEM_CHECK_CYC(MEM_CHECK_CYC)) mmc_config_checker_i (
  .core_clk(core_clk), .resetn(resetn), .apbReq(apbReq), .apbRsp(apbRsp), .cfg(cfg),
  .deviceReady(deviceReady), .configError(configError));
